// *** bench/mcu_instruction_execute_monitor.sv ***
// concurrent checks on the bus and power-down ports of the execute block
`timescale 1ns/1ps
`default_nettype none
`include "mcu_exec_consts.vh"
module mcu_instruction_execute_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [10:0] rom_addr,
	input wire logic [13:0] rom_data,
	input wire logic        wake,
	input wire logic        sleeping
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// a setup cycle, and an accepted instruction write of one operation
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence instr_ok_s(logic [5:0] op);
		setup_s ##0 (pwrite && paddr == `REG_INSTR && pwdata[21:16] == op)
		##1 (pready && !pslverr);
	endsequence

	answer_next_a: assert property (setup_s |=> pready)
		else $error("setup not answered in the next cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	idle_quiet_a: assert property (!pready |-> (prdata == 32'h0 && !pslverr))
		else $error("read data or error outside the access cycle");
	unmapped_refused_a: assert property (setup_s ##0 (paddr > 8'h23) |=> pslverr)
		else $error("unmapped address not refused");
	readonly_refused_a: assert property (setup_s ##0 (pwrite && (paddr == `REG_TBL_HIGH
		|| paddr == `REG_CYCLES || paddr == `REG_DOG_COUNT)) |=> pslverr)
		else $error("write to a read-only register not refused");
	sleep_entry_a: assert property (instr_ok_s(`SLEEP_OP) |-> ##[1:5] sleeping)
		else $error("sleep not entered after the sleep operation");
	sleep_holds_a: assert property (sleeping && !wake |=> sleeping)
		else $error("left sleep without wake");
	wake_leaves_a: assert property (sleeping && wake |=> !sleeping)
		else $error("wake did not end sleep");
	asleep_refuses_a: assert property (sleeping && !wake ##0 setup_s
		##0 (pwrite && paddr == `REG_INSTR) |=> pslverr)
		else $error("instruction accepted while asleep");
	final_page_a: assert property (instr_ok_s(`TBL_FETCH_FINAL_OP)
		|-> ##[1:5] (rom_addr[10:8] == `LAST_PAGE))
		else $error("final-page table read used another page");
endmodule
`default_nettype wire

// *** bench/mcu_instruction_execute_tb.sv ***
// self-checking bench for the instruction execute block
`timescale 1ns/1ps
`default_nettype none
`include "mcu_exec_consts.vh"
module mcu_instruction_execute_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        wake = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, seed = 32'h58400840;
	logic        pready, pslverr, sleeping, er;
	logic [10:0] rom_addr, e_pc;
	logic [7:0]  e_acc, e_mem, e_tptr, d;
	logic [5:0]  e_flg, e_tbl, op, m;
	logic [2:0]  e_cyc;
	logic [10:0] stk [$];
	int          mismatches = 0;
	int          checks = 0;
	logic [5:0]  ops [22] = '{`NOOP_OP, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
		6'h09, 6'h10, 6'h11, 6'h12, 6'h16, 6'h17, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d,
		6'h1e, 6'h1f, `CONJUNCT_IMM_OP};
	logic [7:0]  corner [4] = '{8'h00, 8'h00, 8'hff, 8'h01};
	logic [7:0]  bad [4] = '{`REG_TBL_HIGH, `REG_CYCLES, `REG_DOG_COUNT, 8'h40};
	logic [16:0] flow [10] = '{{`JUMP_OP, 11'h5a3}, {`CALL_OP, 11'h234},
		{`SUB_EXIT_IMM_OP, 11'h09c}, {`CALL_OP, 11'h3ff}, {`CALL_OP, 11'h100},
		{`IRQ_EXIT_OP, 11'h000}, {`SUB_EXIT_OP, 11'h000}, {`DOG_PRECLEAR_FIRST_OP, 11'h0},
		{`DOG_PRECLEAR_SECOND_OP, 11'h0}, {`DOG_CLEAR_OP, 11'h0}};

	// program memory stand-in: every address gives a distinct word
	function automatic logic [13:0] rom_fn(input logic [10:0] a);
		return {a[2:0] ^ 3'h5, ~a};
	endfunction
	wire [13:0] rom_data = rom_fn(rom_addr);

	initial forever #2 pclk = ~pclk;

	mcu_instruction_execute #(.PRESC_W(4)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rom_addr(rom_addr),
		.rom_data(rom_data), .wake(wake), .sleeping(sleeping));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// sum with the four arithmetic flags packed as {wrap, zero, half, carry, result}
	function automatic logic [11:0] add_fn(input logic [7:0] a, b, input logic c);
		logic [8:0] s;
		s = a + b + c;
		return {a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00,
			({1'b0, a[3:0]} + b[3:0] + c) > 5'h0f, s[8], s[7:0]};
	endfunction

	task automatic report_and_stop;
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, exp, input string what);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic fail_wait;
		mismatches++;
		$display("[FAIL] %0t wait ran out", $time);
		report_and_stop();
	endtask

	// one bus transfer; an idle cycle follows so the next setup is never doubled up
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			if (++n > 16) fail_wait();
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// expected state after one instruction
	task automatic predict(input logic [5:0] o, input logic [10:0] x);
		logic [13:0] s;
		logic [10:0] nxt;
		logic        sk;
		{s, sk, nxt, e_cyc} = {14'h0, 1'b0, e_pc + 11'd1, 3'd1};
		case (o)
		`JUMP_OP: {nxt, e_cyc} = {x, 3'd2};
		`CALL_OP: begin
			stk.push_back(nxt);
			{nxt, e_cyc} = {x, 3'd2};
		end
		`SUB_EXIT_OP, `IRQ_EXIT_OP: {nxt, e_cyc} = {stk.pop_back(), 3'd2};
		`SUB_EXIT_IMM_OP: {nxt, e_cyc, e_acc} = {stk.pop_back(), 3'd2, x[7:0]};
		`TBL_FETCH_CURRENT_OP, `TBL_FETCH_FINAL_OP: begin
			s = rom_fn({o == `TBL_FETCH_FINAL_OP ? `LAST_PAGE : e_pc[10:8], e_tptr});
			{e_mem, e_tbl, e_cyc} = {s[7:0], s[13:8], 3'd2};
		end
		`DOG_CLEAR_OP, `DOG_PRECLEAR_SECOND_OP: e_flg[5:4] = 2'b00;
		`SLEEP_OP: e_flg[5:4] = 2'b01;
		`SKIP_NIL_OP: sk = e_mem == 8'h00;
		`SKIP_NIL_COPY_OP: {e_acc, sk} = {e_mem, e_mem == 8'h00};
		`SKIP_NIL_BIT_OP: sk = !e_mem[x[8:6]];
		`SKIP_NONNIL_BIT_OP: sk = e_mem[x[8:6]];
		`INC_SKIP_OP: {e_mem, sk} = {e_mem + 8'h01, e_mem == 8'hff};
		`DEC_SKIP_OP: {e_mem, sk} = {e_mem - 8'h01, e_mem == 8'h01};
		`INC_SKIP_TO_ACC_OP: {e_acc, sk} = {e_mem + 8'h01, e_mem == 8'hff};
		`DEC_SKIP_TO_ACC_OP: {e_acc, sk} = {e_mem - 8'h01, e_mem == 8'h01};
		`BYTE_ZERO_OP: e_mem = 8'h00;
		`BYTE_ONES_OP: e_mem = 8'hff;
		`BIT_ZERO_OP: e_mem[x[8:6]] = 1'b0;
		`NIBBLE_EXCHANGE_OP: e_mem = {e_mem[3:0], e_mem[7:4]};
		`NIBBLE_EXCHANGE_ACC_OP: e_acc = {e_mem[3:0], e_mem[7:4]};
		`CONJUNCT_OP, `CONJUNCT_INTO_MEM_OP, `CONJUNCT_IMM_OP: begin
			s[7:0] = e_acc & (o == `CONJUNCT_IMM_OP ? x[7:0] : e_mem);
			e_flg[`FLG_ZERO] = s[7:0] == 8'h00;
		end
		`NOOP_OP, `DOG_PRECLEAR_FIRST_OP: ;
		default: begin
			s = add_fn(e_acc, o == `SUM_IMM_OP ? x[7:0] : e_mem,
				o <= `SUM_WITH_CARRY_MEM_OP && e_flg[`FLG_CARRY]);
			e_flg[3:0] = s[11:8];
		end
		endcase
		if (o >= `SUM_WITH_CARRY_OP)
			if (o == `SUM_WITH_CARRY_MEM_OP || o == `SUM_INTO_MEM_OP || o == `CONJUNCT_INTO_MEM_OP)
				e_mem = s[7:0];
			else
				e_acc = s[7:0];
		e_cyc = e_cyc + sk;
		e_pc = nxt + sk;
	endtask

	// issue one instruction, then poll until the core is idle again
	task automatic run(input logic [5:0] o, input logic [10:0] x);
		int n;
		n = 0;
		xfer(1'b1, `REG_INSTR, {10'h0, o, 5'h0, x});
		check(er, 1'b0, "instr accepted");
		do begin
			xfer(1'b0, `REG_STATUS, 32'h0);
			if (++n > 16) fail_wait();
		end while (rd[`STAT_BUSY] !== 1'b0);
	endtask

	task automatic step(input logic [5:0] o, input logic [10:0] x);
		predict(o, x);
		run(o, x);
	endtask

	task automatic verify;
		xfer(1'b0, `REG_ACC, 32'h0);
		check(rd, {24'h0, e_acc}, "acc");
		xfer(1'b0, `REG_STATUS, 32'h0);
		check(rd & 32'h3ff, {26'h0, e_flg}, "flags");
		xfer(1'b0, `REG_PC, 32'h0);
		check(rd, {21'h0, e_pc}, "pc");
		xfer(1'b0, `REG_CYCLES, 32'h0);
		check(rd, {29'h0, e_cyc}, "cycles");
		xfer(1'b0, `REG_MEM_DATA, 32'h0);
		check(rd, {24'h0, e_mem}, "mem");
	endtask

	initial begin
		{e_acc, e_flg, e_pc, e_cyc} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, `REG_STATUS, 32'h0);
		check(rd, 32'h0, "status after reset");
		xfer(1'b0, `REG_PC, 32'h0);
		check(rd, 32'h0, "pc after reset");
		foreach (bad[k]) begin
			xfer(1'b1, bad[k], 32'h1);
			check(er, 1'b1, "write refused");
		end
		// every listed operation, first with random bytes, then with corner bytes
		for (int i = 0; i < 88; i++) begin
			{op, m, d} = {ops[i % 22], 6'h08 + 6'(rnd() % 56), 8'(i < 22 ? rnd() : corner[i / 22])};
			xfer(1'b1, `REG_MEM_PTR, {26'h0, m});
			xfer(1'b1, `REG_MEM_DATA, {24'h0, d});
			{e_mem, e_acc, e_flg[3:0]} = {d, 12'(rnd())};
			xfer(1'b1, `REG_ACC, {24'h0, e_acc});
			xfer(1'b1, `REG_STATUS, {26'h0, e_flg});
			step(op, 11'(rnd() & 32'h7c0) | m);
			verify();
		end
		// branches, calls, returns and the watchdog clears, expiry and sleep flags preset
		foreach (flow[k]) begin
			e_flg = {2'b11, 4'(rnd())};
			xfer(1'b1, `REG_STATUS, {26'h0, e_flg});
			step(flow[k][16:11], flow[k][10:0]);
			verify();
		end
		xfer(1'b0, `REG_DOG_COUNT, 32'h0);
		check(rd, 32'h0, "dog count");
		xfer(1'b1, `REG_MEM_PTR, {26'h0, `TBLP_MADDR});
		e_tptr = rnd();
		xfer(1'b1, `REG_MEM_DATA, {24'h0, e_tptr});
		xfer(1'b1, `REG_MEM_PTR, 32'h21);
		for (int k = 0; k < 2; k++) begin
			step(k ? `TBL_FETCH_FINAL_OP : `TBL_FETCH_CURRENT_OP, 11'h021);
			verify();
			xfer(1'b0, `REG_TBL_HIGH, 32'h0);
			check(rd, {26'h0, e_tbl}, "table high");
		end
		// clearing the program counter low byte: no memory write, one extra cycle
		run(`BYTE_ZERO_OP, {5'h0, `PCL_MADDR});
		{e_pc, e_cyc} = {e_pc[10:8], 8'h00, 3'd2};
		verify();
		e_flg[5:4] = 2'b10;
		xfer(1'b1, `REG_STATUS, {26'h0, e_flg});
		step(`SLEEP_OP, 11'h0);
		check(sleeping, 1'b1, "asleep");
		xfer(1'b1, `REG_INSTR, 32'h0);
		check(er, 1'b1, "instr refused asleep");
		wake <= 1'b1;
		@(posedge pclk);
		wake <= 1'b0;
		@(posedge pclk);
		check(sleeping, 1'b0, "awake");
		verify();
		xfer(1'b0, `REG_DOG_COUNT, 32'h0);
		check(rd, 32'h0, "dog count after sleep");
		report_and_stop();
	end
endmodule

bind mcu_instruction_execute mcu_instruction_execute_monitor mon (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rom_addr(rom_addr), .rom_data(rom_data), .wake(wake), .sleeping(sleeping));
`default_nettype wire

// *** rtl/alu_unit.v ***
// add, add with carry and and unit with the four arithmetic flags
`timescale 1ns/1ps
`default_nettype none
module alu_unit (
	input  wire       [7:0] a,
	input  wire       [7:0] b,
	input  wire             cin,
	input  wire             logic_sel,
	output wire       [7:0] res,
	output wire             carry,
	output wire             half_bit_outflow,
	output wire             signed_wrap,
	output wire             zero
);
	wire [4:0] lo_sum;
	wire [8:0] sum;

	// nine-bit sum keeps the carry out, five-bit low sum the nibble carry
	assign lo_sum           = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
	assign sum              = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	assign res              = logic_sel ? (a & b) : sum[7:0];
	assign carry            = sum[8];
	assign half_bit_outflow = lo_sum[4];
	// like signs in, unlike sign out
	assign signed_wrap      = (a[7] == b[7]) && (sum[7] != a[7]);
	assign zero             = (res == 8'h00);
endmodule
`default_nettype wire

// *** rtl/mcu_exec_consts.vh ***
// shared constants for the instruction execute block, its monitor and its bench
`ifndef MCU_EXEC_CONSTS_VH
`define MCU_EXEC_CONSTS_VH

// apb register byte offsets
`define REG_INSTR     8'h00
`define REG_STATUS    8'h04
`define REG_PC        8'h08
`define REG_ACC       8'h0c
`define REG_TBL_HIGH  8'h10
`define REG_CYCLES    8'h14
`define REG_MEM_PTR   8'h18
`define REG_MEM_DATA  8'h1c
`define REG_DOG_COUNT 8'h20

// instruction word fields
`define OP_MSB   21
`define OP_LSB   16
`define ADDR_MSB 10
`define BIT_MSB  8
`define BIT_LSB  6
`define M_MSB    5

// status flag positions
`define FLG_CARRY  0
`define FLG_HALF   1
`define FLG_ZERO   2
`define FLG_WRAP   3
`define FLG_SLEEP  4
`define FLG_EXPIRY 5
`define STAT_BUSY  8
`define STAT_SLEEP 9

// data memory locations and the program page with special meaning
`define PCL_MADDR  6'h02
`define TBLP_MADDR 6'h07
`define LAST_PAGE  3'h7

// reset values
`define ACC_RST   8'h00
`define PC_RST    11'h000
`define FLAGS_RST 6'h00

// one instruction cycle is four system clocks
`define SYS_PER_INSN 4
`define DIV_LAST     2'h3

// operation codes
`define NOOP_OP                6'h00
`define JUMP_OP                6'h01
`define SKIP_NIL_OP            6'h02
`define SKIP_NIL_COPY_OP       6'h03
`define SKIP_NIL_BIT_OP        6'h04
`define SKIP_NONNIL_BIT_OP     6'h05
`define INC_SKIP_OP            6'h06
`define DEC_SKIP_OP            6'h07
`define INC_SKIP_TO_ACC_OP     6'h08
`define DEC_SKIP_TO_ACC_OP     6'h09
`define CALL_OP                6'h0a
`define SUB_EXIT_OP            6'h0b
`define SUB_EXIT_IMM_OP        6'h0c
`define IRQ_EXIT_OP            6'h0d
`define TBL_FETCH_CURRENT_OP   6'h0e
`define TBL_FETCH_FINAL_OP     6'h0f
`define BYTE_ZERO_OP           6'h10
`define BYTE_ONES_OP           6'h11
`define BIT_ZERO_OP            6'h12
`define DOG_CLEAR_OP           6'h13
`define DOG_PRECLEAR_FIRST_OP  6'h14
`define DOG_PRECLEAR_SECOND_OP 6'h15
`define NIBBLE_EXCHANGE_OP     6'h16
`define NIBBLE_EXCHANGE_ACC_OP 6'h17
`define SLEEP_OP               6'h18
`define SUM_WITH_CARRY_OP      6'h19
`define SUM_WITH_CARRY_MEM_OP  6'h1a
`define SUM_OP                 6'h1b
`define SUM_INTO_MEM_OP        6'h1c
`define SUM_IMM_OP             6'h1d
`define CONJUNCT_OP            6'h1e
`define CONJUNCT_INTO_MEM_OP   6'h1f
`define CONJUNCT_IMM_OP        6'h20

`endif

// *** rtl/mcu_instruction_execute.v ***
// decode and execute stage of an 8-bit core, driven one instruction at a time over apb
// Notes on behaviour
// RULE1: writing the program counter low byte adds one instruction cycle (four clocks).
// RULE2: a taken skip adds one instruction cycle; untaken keeps the listed count.
// RULE3: jump takes two cycles, loads the target address, leaves flags alone.
// RULE4: skip-if-zero skips on zero byte; copy form also loads accumulator; no flags.
// RULE5: bit tests skip when selected bit is zero, or nonzero for the other form.
// RULE6: increment/decrement-and-skip write memory back, skip on zero, both penalties.
// RULE7: accumulator forms put result in accumulator only, skip when it is zero.
// RULE8: call pushes next address, loads target, two cycles, no flag change.
// RULE9: the three returns take two cycles; immediate form also loads accumulator.
// RULE10: table reads fetch current or last page word to memory and high latch.
// RULE11: a pre-clear clears expiry and sleep flags only if it clears the watchdog.
// RULE12: nibble exchange swaps halves in place or into accumulator, no flags.
// RULE13: add with carry sums accumulator, byte, carry; updates four arithmetic flags.
// RULE14: plain add with byte or immediate updates the four arithmetic flags.
// RULE15: and with byte or immediate updates only the zero flag.
// RULE16: byte clear writes zero; bit clear zeroes only the chosen bit; no flags.
// RULE17: sleep takes one cycle and touches only the expiry and sleep flags.
// RULE18: sleep stops execution and clock, keeps state, clears watchdog and prescaler.
// RULE19: watchdog clear zeroes the count and both expiry and sleep flags.
// RULE20: one pre-clear alone only records itself; both together clear the watchdog.
// RULE21: byte set writes all ones without touching flags.
// RULE22: no-operation advances the program counter by one in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "mcu_exec_consts.vh"
module mcu_instruction_execute #(
	parameter RAM_DEPTH   = 64,
	parameter STACK_DEPTH = 6,
	parameter PRESC_W     = 4
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire             psel,
	input  wire             penable,
	input  wire             pwrite,
	input  wire       [7:0] paddr,
	input  wire      [31:0] pwdata,
	output reg       [31:0] prdata,
	output reg              pready,
	output reg              pslverr,
	output reg       [10:0] rom_addr,
	input  wire      [13:0] rom_data,
	input  wire             wake,
	output reg              sleeping
);
	localparam ST_IDLE = 3'b001;
	localparam ST_RUN  = 3'b010;
	localparam ST_WAIT = 3'b100;

	reg         [2:0] state_reg;
	reg        [31:0] ins_reg;
	reg        [10:0] pc_reg;
	reg         [7:0] acc_reg;
	reg         [5:0] flags_reg;
	reg         [5:0] upper_table_latch;
	reg         [1:0] div_reg;
	reg [PRESC_W-1:0] presc_reg;
	reg         [7:0] dog_count_reg;
	reg               pre_first_reg;
	reg               pre_second_reg;
	reg         [1:0] left_reg;
	reg         [2:0] cycles_reg;
	reg         [5:0] mem_ptr_reg;
	reg         [2:0] sp_reg;
	reg         [7:0] ram [0:RAM_DEPTH-1];
	reg        [10:0] stk [0:STACK_DEPTH-1];

	// data memory read; the low program counter byte overlays its location
	function [7:0] mem_read(input [5:0] a);
		begin
			if (a == `PCL_MADDR) begin
				mem_read = pc_reg[7:0];
			end else begin
				mem_read = ram[a];
			end
		end
	endfunction

	// instruction fields
	wire  [5:0] op   = ins_reg[`OP_MSB:`OP_LSB];
	wire  [5:0] m    = ins_reg[`M_MSB:0];
	wire  [2:0] bsel = ins_reg[`BIT_MSB:`BIT_LSB];
	wire  [7:0] imm  = ins_reg[7:0];
	wire [10:0] tgt  = ins_reg[`ADDR_MSB:0];
	wire  [7:0] mval = mem_read(m);

	// one instruction cycle every four clocks; frozen while asleep
	wire tick   = (div_reg == `DIV_LAST) && !sleeping;
	wire busy   = (state_reg != ST_IDLE);
	wire ex_go  = (state_reg == ST_RUN) && tick;
	wire setup  = psel && !penable;
	wire access = psel && penable && pready;
	wire wr_go  = access && pwrite && !pslverr;
	wire presc_tick = tick && (&presc_reg);
	wire dog_wrap   = presc_tick && (dog_count_reg == 8'hff);

	// arithmetic operand selection
	wire imm_form = (op == `SUM_IMM_OP) || (op == `CONJUNCT_IMM_OP);
	wire with_c   = (op == `SUM_WITH_CARRY_OP) || (op == `SUM_WITH_CARRY_MEM_OP);
	wire and_form = (op == `CONJUNCT_OP) || (op == `CONJUNCT_INTO_MEM_OP) ||
		(op == `CONJUNCT_IMM_OP);
	wire [7:0] alu_res;
	wire       alu_c;
	wire       alu_h;
	wire       alu_w;
	wire       alu_z;

	alu_unit u_alu (
		.a                (acc_reg),
		.b                (imm_form ? imm : mval),
		.cin              (with_c & flags_reg[`FLG_CARRY]),
		.logic_sel        (and_form),
		.res              (alu_res),
		.carry            (alu_c),
		.half_bit_outflow (alu_h),
		.signed_wrap      (alu_w),
		.zero             (alu_z)
	);

	reg  [7:0] ex_res;
	reg        ex_wm;
	reg        ex_wa;
	reg        ex_skip;
	reg  [2:0] ex_base;
	reg [10:0] ex_pc;
	reg  [5:0] ex_flags;
	reg        ex_push;
	reg        ex_pop;
	reg        ex_tbl;
	reg        ex_dogclr;
	reg        ex_halt;
	reg        ex_pre1;
	reg        ex_pre2;

	// execution of the held instruction, applied at the next instruction cycle
	always @* begin
		ex_res    = 8'h00;
		ex_wm     = 1'b0;
		ex_wa     = 1'b0;
		ex_skip   = 1'b0;
		ex_base   = 3'd1;
		ex_pc     = pc_reg + 11'd1; // see RULE22
		ex_flags  = flags_reg;
		ex_push   = 1'b0;
		ex_pop    = 1'b0;
		ex_tbl    = 1'b0;
		ex_dogclr = 1'b0;
		ex_halt   = 1'b0;
		ex_pre1   = pre_first_reg;
		ex_pre2   = pre_second_reg;
		case (op)
			`JUMP_OP: begin
				ex_base = 3'd2; // see RULE3
				ex_pc   = tgt;
			end
			`SKIP_NIL_OP: begin
				ex_skip = (mval == 8'h00); // see RULE4
			end
			`SKIP_NIL_COPY_OP: begin
				ex_res  = mval;
				ex_wa   = 1'b1;
				ex_skip = (mval == 8'h00); // see RULE4
			end
			`SKIP_NIL_BIT_OP: begin
				ex_skip = !mval[bsel]; // see RULE5
			end
			`SKIP_NONNIL_BIT_OP: begin
				ex_skip = mval[bsel]; // see RULE5
			end
			`INC_SKIP_OP, `DEC_SKIP_OP: begin
				ex_res  = (op == `INC_SKIP_OP) ? mval + 8'h01 : mval - 8'h01;
				ex_wm   = 1'b1;
				ex_skip = (ex_res == 8'h00); // see RULE6
			end
			`INC_SKIP_TO_ACC_OP, `DEC_SKIP_TO_ACC_OP: begin
				ex_res  = (op == `INC_SKIP_TO_ACC_OP) ? mval + 8'h01 : mval - 8'h01;
				ex_wa   = 1'b1;
				ex_skip = (ex_res == 8'h00); // see RULE7
			end
			`CALL_OP: begin
				ex_base = 3'd2; // see RULE8
				ex_push = 1'b1;
				ex_pc   = tgt;
			end
			`SUB_EXIT_OP, `IRQ_EXIT_OP, `SUB_EXIT_IMM_OP: begin
				ex_base = 3'd2; // see RULE9
				ex_pop  = 1'b1;
				ex_pc   = stk[sp_reg - 3'd1];
				ex_res  = imm;
				ex_wa   = (op == `SUB_EXIT_IMM_OP);
			end
			`TBL_FETCH_CURRENT_OP, `TBL_FETCH_FINAL_OP: begin
				ex_base = 3'd2; // see RULE10
				ex_res  = rom_data[7:0];
				ex_wm   = 1'b1;
				ex_tbl  = 1'b1;
			end
			`BYTE_ZERO_OP: begin
				ex_res = 8'h00; // see RULE16
				ex_wm  = 1'b1;
			end
			`BYTE_ONES_OP: begin
				ex_res = 8'hff; // see RULE21
				ex_wm  = 1'b1;
			end
			`BIT_ZERO_OP: begin
				ex_res = mval & ~(8'h01 << bsel); // see RULE16
				ex_wm  = 1'b1;
			end
			`DOG_CLEAR_OP: begin
				ex_dogclr = 1'b1; // see RULE19
			end
			`DOG_PRECLEAR_FIRST_OP, `DOG_PRECLEAR_SECOND_OP: begin
				// the partner having run already completes the pair
				if ((op == `DOG_PRECLEAR_FIRST_OP) ? pre_second_reg : pre_first_reg) begin
					ex_dogclr = 1'b1; // see RULE11
					ex_pre1   = 1'b0;
					ex_pre2   = 1'b0;
				end else if (op == `DOG_PRECLEAR_FIRST_OP) begin
					ex_pre1 = 1'b1; // see RULE20
				end else begin
					ex_pre2 = 1'b1; // see RULE20
				end
			end
			`NIBBLE_EXCHANGE_OP: begin
				ex_res = {mval[3:0], mval[7:4]}; // see RULE12
				ex_wm  = 1'b1;
			end
			`NIBBLE_EXCHANGE_ACC_OP: begin
				ex_res = {mval[3:0], mval[7:4]}; // see RULE12
				ex_wa  = 1'b1;
			end
			`SLEEP_OP: begin
				ex_halt                = 1'b1; // see RULE17
				ex_dogclr              = 1'b1;
				ex_flags[`FLG_SLEEP]   = 1'b1; // see RULE18
				ex_flags[`FLG_EXPIRY]  = 1'b0;
			end
			`SUM_WITH_CARRY_OP, `SUM_WITH_CARRY_MEM_OP, `SUM_OP, `SUM_INTO_MEM_OP,
			`SUM_IMM_OP: begin
				ex_res              = alu_res; // see RULE13
				ex_wm               = (op == `SUM_WITH_CARRY_MEM_OP) || (op == `SUM_INTO_MEM_OP);
				ex_wa               = !ex_wm;
				ex_flags[`FLG_CARRY] = alu_c; // see RULE14
				ex_flags[`FLG_HALF]  = alu_h;
				ex_flags[`FLG_WRAP]  = alu_w;
				ex_flags[`FLG_ZERO]  = alu_z;
			end
			`CONJUNCT_OP, `CONJUNCT_INTO_MEM_OP, `CONJUNCT_IMM_OP: begin
				ex_res              = alu_res;
				ex_wm               = (op == `CONJUNCT_INTO_MEM_OP);
				ex_wa               = !ex_wm;
				ex_flags[`FLG_ZERO] = alu_z; // see RULE15
			end
			default: begin
				ex_base = 3'd1;
			end
		endcase
		if (ex_dogclr) begin
			ex_flags[`FLG_EXPIRY] = 1'b0;
			ex_flags[`FLG_SLEEP]  = ex_halt; // see RULE19
		end
	end

	// penalties: a skip steps over the next word, a low-byte load redirects
	wire        ex_pcl   = ex_wm && (m == `PCL_MADDR);
	wire  [2:0] ex_total = ex_base + {2'b00, ex_skip} + {2'b00, ex_pcl}; // see RULE1
	wire [10:0] pc_final = ex_pcl ? {pc_reg[10:8], ex_res} :
		(ex_skip ? pc_reg + 11'd2 : ex_pc); // see RULE2

	reg [31:0] rd_val;
	reg        rd_err;

	// register decode; writes to live state are refused while an instruction runs
	always @* begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		if (paddr == `REG_INSTR) begin
			rd_val = ins_reg;
			rd_err = pwrite && (busy || sleeping);
		end else if (paddr == `REG_STATUS) begin
			rd_val = {22'h000000, sleeping, busy, 2'b00, flags_reg};
			rd_err = pwrite && busy;
		end else if (paddr == `REG_PC) begin
			rd_val = {21'h000000, pc_reg};
			rd_err = pwrite && busy;
		end else if (paddr == `REG_ACC) begin
			rd_val = {24'h000000, acc_reg};
			rd_err = pwrite && busy;
		end else if (paddr == `REG_TBL_HIGH) begin
			rd_val = {26'h0000000, upper_table_latch};
			rd_err = pwrite;
		end else if (paddr == `REG_CYCLES) begin
			rd_val = {29'h00000000, cycles_reg};
			rd_err = pwrite;
		end else if (paddr == `REG_MEM_PTR) begin
			rd_val = {26'h0000000, mem_ptr_reg};
		end else if (paddr == `REG_MEM_DATA) begin
			rd_val = {24'h000000, mem_read(mem_ptr_reg)};
			rd_err = pwrite && busy;
		end else if (paddr == `REG_DOG_COUNT) begin
			rd_val = {24'h000000, dog_count_reg};
			rd_err = pwrite;
		end else begin
			rd_err = 1'b1;
		end
	end

	// data memory: core result or software write, never both since software waits
	always @(posedge pclk) begin
		if (ex_go && ex_wm && !ex_pcl) begin
			ram[m] <= ex_res; // see RULE6
		end else if (wr_go && paddr == `REG_MEM_DATA) begin
			ram[mem_ptr_reg] <= pwdata[7:0];
		end
	end

	// return stack; a push beyond the last level is dropped
	always @(posedge pclk) begin
		if (ex_go && ex_push && sp_reg < STACK_DEPTH) begin
			stk[sp_reg] <= pc_reg + 11'd1; // see RULE8
		end
	end

	// control state, apb answer, watchdog and sequencing
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg         <= ST_IDLE;
			ins_reg           <= 32'h0000_0000;
			pc_reg            <= `PC_RST;
			acc_reg           <= `ACC_RST;
			flags_reg         <= `FLAGS_RST;
			upper_table_latch <= 6'h00;
			div_reg           <= 2'h0;
			presc_reg         <= {PRESC_W{1'b0}};
			dog_count_reg     <= 8'h00;
			pre_first_reg     <= 1'b0;
			pre_second_reg    <= 1'b0;
			left_reg          <= 2'h0;
			cycles_reg        <= 3'h0;
			mem_ptr_reg       <= 6'h00;
			sp_reg            <= 3'h0;
			prdata            <= 32'h0000_0000;
			pready            <= 1'b0;
			pslverr           <= 1'b0;
			rom_addr          <= 11'h000;
			sleeping          <= 1'b0;
		end else begin
			// zero-wait answer: ready through the access phase only
			pready  <= setup;
			prdata  <= setup ? rd_val : 32'h0000_0000;
			pslverr <= setup && rd_err;
			if (!sleeping) begin
				div_reg <= div_reg + 2'h1; // clock stopped while asleep, see RULE18
			end else if (wake) begin
				sleeping <= 1'b0;
			end
			if (tick) begin
				presc_reg <= presc_reg + {{(PRESC_W-1){1'b0}}, 1'b1};
			end
			if (presc_tick) begin
				dog_count_reg <= dog_count_reg + 8'h01;
			end
			if (wr_go) begin
				if (paddr == `REG_INSTR) begin
					ins_reg   <= pwdata;
					state_reg <= ST_RUN;
					// table word address is ready well before the next cycle
					rom_addr  <= {(pwdata[`OP_MSB:`OP_LSB] == `TBL_FETCH_FINAL_OP) ?
						`LAST_PAGE : pc_reg[10:8], ram[`TBLP_MADDR]}; // see RULE10
				end else if (paddr == `REG_STATUS) begin
					flags_reg <= pwdata[5:0];
				end else if (paddr == `REG_PC) begin
					pc_reg <= pwdata[10:0];
				end else if (paddr == `REG_ACC) begin
					acc_reg <= pwdata[7:0];
				end else if (paddr == `REG_MEM_PTR) begin
					mem_ptr_reg <= pwdata[5:0];
				end
			end
			if (ex_go) begin
				pc_reg         <= pc_final;
				flags_reg      <= ex_flags;
				pre_first_reg  <= ex_pre1;
				pre_second_reg <= ex_pre2;
				cycles_reg     <= ex_total;
				if (ex_wa) begin
					acc_reg <= ex_res; // see RULE7
				end
				if (ex_tbl) begin
					upper_table_latch <= rom_data[13:8];
				end
				if (ex_push && sp_reg < STACK_DEPTH) begin
					sp_reg <= sp_reg + 3'd1;
				end else if (ex_pop && sp_reg != 3'd0) begin
					sp_reg <= sp_reg - 3'd1; // see RULE9
				end
				if (ex_dogclr) begin
					dog_count_reg <= 8'h00; // see RULE19
					presc_reg     <= {PRESC_W{1'b0}};
				end
				if (ex_halt) begin
					sleeping <= 1'b1; // see RULE18
				end
				if (ex_total == 3'd1) begin
					state_reg <= ST_IDLE;
				end else begin
					left_reg  <= ex_total[1:0] - 2'h1;
					state_reg <= ST_WAIT;
				end
			end else if (state_reg == ST_WAIT && tick) begin
				if (left_reg == 2'h1) begin
					state_reg <= ST_IDLE;
				end else begin
					left_reg <= left_reg - 2'h1;
				end
			end
			// an expiry in the same cycle as a clear still lands
			if (dog_wrap) begin
				flags_reg[`FLG_EXPIRY] <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire
